// *** core/swf_defs.vh ***
// constants for the serial write frame engine
`ifndef SWF_DEFS_VH
`define SWF_DEFS_VH
`define SWF_FN_SINGLE  8'h06
`define SWF_FN_MULTI   8'h10
`define SWF_MAX_WORDS  20
`define SWF_CRC_INIT   16'hffff
`define SWF_CRC_POLY   16'ha001
`define SWF_CH_COLON   8'h3a
`define SWF_CH_CR      8'h0d
`define SWF_CH_LF      8'h0a
`define SWF_HDR_BYTES  6
`define SWF_MEM_AW     5
`endif

// *** core/swf_frame.v ***
// serial register write framer and checker
// Function
// - multi write holds at most twenty values
// - values are two bytes, high first
// - ascii check sums address through data
// - ascii check is negated sum, hex
// - cyclic check preset to all ones
// - each byte xored into low eight
// - shift right, xor a001 on carry
// - eight shift steps per byte
// - all bytes in order give check
// - cyclic check sent low byte first
`timescale 1ns/10ps
`include "swf_defs.vh"
module swf_frame (
    input  wire        clk_sys_in,
    input  wire        nrst_in,
    input  wire        ascii_mode_in,
    input  wire [7:0]  station_addr_in,
    input  wire        rx_valid_in,
    input  wire [7:0]  rx_byte_in,
    input  wire        rx_frame_end_in,
    input  wire        tx_ready_in,
    output reg         tx_valid_out,
    output reg  [7:0]  tx_data_out,
    output reg         wr_valid_out,
    output reg  [15:0] wr_addr_out,
    output reg  [15:0] wr_data_out,
    output reg         frame_ok_out,
    output reg         frame_err_out,
    output reg         busy_out
);
    localparam [2:0] S_IDLE = 3'h0, S_RX = 3'h1, S_LF = 3'h2, S_CHK = 3'h3, S_WR = 3'h4, S_TX = 3'h5;
    localparam [2:0] P_SOF = 3'h0, P_BYTE = 3'h1, P_CR = 3'h2, P_LF = 3'h3, P_DONE = 3'h4;

    reg        rst_s1_q, rst_s2_q;
    reg [2:0]  state_q;
    reg [7:0]  idx_q;
    reg [15:0] crc_q;
    reg [7:0]  lrc_q;
    reg        nib_half_q;
    reg [3:0]  nib_q;
    reg        bad_q;
    reg [7:0]  addr_q, func_q, bcnt_q, hi_q;
    reg [15:0] reg_q, fld_q;
    reg [4:0]  words_q, wk_q;
    reg        rd_pend_q;
    reg [2:0]  ph_q;
    reg [3:0]  tx_idx_q;
    reg        tx_nib_q;
    reg [15:0] txc_q;
    reg [7:0]  txl_q;

    wire        rst_n = rst_s2_q;
    wire [15:0] rd_data;

    // one byte of the cyclic check
    function [15:0] crc_byte;
        input [15:0] c;
        input [7:0]  b;
        integer      k;
        reg [15:0]   r;
        begin
            r = c ^ {8'h00, b};
            for (k = 0; k < 8; k = k + 1) begin
                r = r[0] ? ((r >> 1) ^ `SWF_CRC_POLY) : (r >> 1);
            end
            crc_byte = r;
        end
    endfunction

    function [4:0] hex_val;
        input [7:0] ch;
        begin
            if (ch >= 8'h30 && ch <= 8'h39) begin
                hex_val = {1'b1, ch[3:0]};
            end else if (ch >= 8'h41 && ch <= 8'h46) begin
                hex_val = {1'b1, ch[3:0] + 4'h9};
            end else begin
                hex_val = 5'h00;
            end
        end
    endfunction

    function [7:0] hex_char;
        input [3:0] n;
        begin
            hex_char = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
        end
    endfunction

    // byte capture from either framing
    reg        fire;
    reg [7:0]  fb;
    reg [4:0]  hv;
    wire       in_idle = (state_q == S_IDLE);
    wire [7:0] idx_b = in_idle ? 8'h00 : idx_q;
    wire [15:0] crc_b = in_idle ? `SWF_CRC_INIT : crc_q;
    wire [7:0] lrc_b = in_idle ? 8'h00 : lrc_q;

    always @* begin
        hv = hex_val(rx_byte_in);
        fire = 1'b0;
        fb = rx_byte_in;
        if (rx_valid_in && !ascii_mode_in && (in_idle || state_q == S_RX)) begin
            fire = 1'b1;
        end else if (rx_valid_in && ascii_mode_in && state_q == S_RX && hv[4] && nib_half_q) begin
            fire = 1'b1;
            fb = {nib_q, hv[3:0]};
        end
    end

    // frame acceptance
    wire [1:0] chk_n = ascii_mode_in ? 2'd1 : 2'd2;
    wire       chk_ok = ascii_mode_in ? (lrc_q == 8'h00) : (crc_q == 16'h0000);
    wire       cnt_ok = (fld_q != 16'h0000) && (fld_q <= `SWF_MAX_WORDS);
    wire [7:0] dbl = {fld_q[6:0], 1'b0};
    wire       single_ok = (func_q == `SWF_FN_SINGLE) && (idx_q == 8'd6 + {6'h00, chk_n});
    wire       multi_ok = (func_q == `SWF_FN_MULTI) && cnt_ok && (bcnt_q == dbl)
                          && (idx_q == 8'd7 + dbl + {6'h00, chk_n});
    wire       addr_hit = (addr_q == station_addr_in);
    wire       accept = addr_hit && chk_ok && !bad_q && (single_ok || multi_ok);

    // data word capture
    wire [7:0] dw = (idx_b - 8'd8) >> 1;
    wire       mem_we = fire && ((idx_b == 8'd5) || (idx_b >= 8'd8 && !idx_b[0] && dw < `SWF_MAX_WORDS));
    wire [4:0] mem_wa = (idx_b == 8'd5) ? 5'd0 : dw[4:0];
    wire [15:0] mem_wd = (idx_b == 8'd5) ? {fld_q[15:8], fb} : {hi_q, fb};

    swf_word_mem #(
        .WIDTH (16),
        .DEPTH (`SWF_MAX_WORDS),
        .AW    (`SWF_MEM_AW)
    ) u_mem (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  (mem_wa),
        .wr_data_in  (mem_wd),
        .rd_addr_in  (wk_q),
        .rd_data_out (rd_data)
    );

    // response byte selection
    reg [7:0] tb;
    wire [3:0] tx_last = ascii_mode_in ? 4'd6 : 4'd7;
    always @* begin
        case (tx_idx_q)
            4'd0: tb = addr_q;
            4'd1: tb = func_q;
            4'd2: tb = reg_q[15:8];
            4'd3: tb = reg_q[7:0];
            4'd4: tb = fld_q[15:8];
            4'd5: tb = fld_q[7:0];
            4'd6: tb = ascii_mode_in ? (8'h00 - txl_q) : txc_q[7:0];
            default: tb = txc_q[15:8];
        endcase
    end

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            idx_q <= 8'h00;
            crc_q <= `SWF_CRC_INIT;
            lrc_q <= 8'h00;
            nib_half_q <= 1'b0;
            nib_q <= 4'h0;
            bad_q <= 1'b0;
            addr_q <= 8'h00;
            func_q <= 8'h00;
            bcnt_q <= 8'h00;
            hi_q <= 8'h00;
            reg_q <= 16'h0000;
            fld_q <= 16'h0000;
            words_q <= 5'h00;
            wk_q <= 5'h00;
            rd_pend_q <= 1'b0;
            ph_q <= P_DONE;
            tx_idx_q <= 4'h0;
            tx_nib_q <= 1'b0;
            txc_q <= `SWF_CRC_INIT;
            txl_q <= 8'h00;
            tx_valid_out <= 1'b0;
            tx_data_out <= 8'h00;
            wr_valid_out <= 1'b0;
            wr_addr_out <= 16'h0000;
            wr_data_out <= 16'h0000;
            frame_ok_out <= 1'b0;
            frame_err_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            wr_valid_out <= 1'b0;
            frame_ok_out <= 1'b0;
            frame_err_out <= 1'b0;
            busy_out <= (state_q == S_CHK) || (state_q == S_WR) || (state_q == S_TX);
            if (fire) begin
                crc_q <= crc_byte(crc_b, fb);
                lrc_q <= lrc_b + fb;
                if (idx_b != 8'hff) begin
                    idx_q <= idx_b + 8'd1;
                end
                case (idx_b)
                    8'd0: addr_q <= fb;
                    8'd1: func_q <= fb;
                    8'd2: reg_q[15:8] <= fb;
                    8'd3: reg_q[7:0] <= fb;
                    8'd4: fld_q[15:8] <= fb;
                    8'd5: fld_q[7:0] <= fb;
                    8'd6: bcnt_q <= fb;
                    default: hi_q <= fb;
                endcase
            end
            case (state_q)
                S_IDLE: begin
                    bad_q <= 1'b0;
                    nib_half_q <= 1'b0;
                    if (ascii_mode_in && rx_valid_in && rx_byte_in == `SWF_CH_COLON) begin
                        state_q <= S_RX;
                        idx_q <= 8'h00;
                        crc_q <= `SWF_CRC_INIT;
                        lrc_q <= 8'h00;
                    end else if (fire) begin
                        state_q <= S_RX;
                    end
                end
                S_RX: begin
                    if (!ascii_mode_in) begin
                        if (rx_frame_end_in) begin
                            state_q <= S_CHK;
                        end
                    end else if (rx_valid_in) begin
                        if (rx_byte_in == `SWF_CH_CR) begin
                            bad_q <= bad_q | nib_half_q;
                            state_q <= S_LF;
                        end else if (rx_byte_in == `SWF_CH_COLON) begin
                            idx_q <= 8'h00;
                            crc_q <= `SWF_CRC_INIT;
                            lrc_q <= 8'h00;
                            bad_q <= 1'b0;
                            nib_half_q <= 1'b0;
                        end else if (hv[4]) begin
                            nib_q <= hv[3:0];
                            nib_half_q <= !nib_half_q;
                        end else begin
                            bad_q <= 1'b1;
                        end
                    end
                end
                S_LF: begin
                    if (rx_valid_in) begin
                        bad_q <= bad_q | (rx_byte_in != `SWF_CH_LF);
                        state_q <= S_CHK;
                    end
                end
                S_CHK: begin
                    wk_q <= 5'h00;
                    rd_pend_q <= 1'b0;
                    words_q <= (func_q == `SWF_FN_SINGLE) ? 5'd1 : fld_q[4:0];
                    ph_q <= ascii_mode_in ? P_SOF : P_BYTE;
                    tx_idx_q <= 4'h0;
                    tx_nib_q <= 1'b0;
                    txc_q <= `SWF_CRC_INIT;
                    txl_q <= 8'h00;
                    frame_ok_out <= accept;
                    frame_err_out <= addr_hit && !accept;
                    state_q <= accept ? S_WR : S_IDLE;
                end
                S_WR: begin
                    rd_pend_q <= !rd_pend_q;
                    if (rd_pend_q) begin
                        wr_valid_out <= 1'b1;
                        wr_addr_out <= reg_q + {11'h000, wk_q};
                        wr_data_out <= rd_data;
                        wk_q <= wk_q + 5'd1;
                        if (wk_q + 5'd1 == words_q) begin
                            state_q <= S_TX;
                        end
                    end
                end
                S_TX: begin
                    if (!tx_valid_out || tx_ready_in) begin
                        tx_valid_out <= 1'b1;
                        case (ph_q)
                            P_SOF: begin
                                tx_data_out <= `SWF_CH_COLON;
                                ph_q <= P_BYTE;
                            end
                            P_BYTE: begin
                                if (ascii_mode_in && !tx_nib_q) begin
                                    tx_data_out <= hex_char(tb[7:4]);
                                    tx_nib_q <= 1'b1;
                                end else begin
                                    tx_data_out <= ascii_mode_in ? hex_char(tb[3:0]) : tb;
                                    tx_nib_q <= 1'b0;
                                    if (tx_idx_q < `SWF_HDR_BYTES) begin
                                        txc_q <= crc_byte(txc_q, tb);
                                        txl_q <= txl_q + tb;
                                    end
                                    if (tx_idx_q == tx_last) begin
                                        ph_q <= ascii_mode_in ? P_CR : P_DONE;
                                    end else begin
                                        tx_idx_q <= tx_idx_q + 4'd1;
                                    end
                                end
                            end
                            P_CR: begin
                                tx_data_out <= `SWF_CH_CR;
                                ph_q <= P_LF;
                            end
                            P_LF: begin
                                tx_data_out <= `SWF_CH_LF;
                                ph_q <= P_DONE;
                            end
                            default: begin
                                tx_valid_out <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// *** core/swf_word_mem.v ***
// word store for the register values of one frame
`timescale 1ns/10ps
module swf_word_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 20,
    parameter AW    = 5
) (
    input  wire             clk_sys_in,
    input  wire             wr_en_in,
    input  wire [AW-1:0]    wr_addr_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire [AW-1:0]    rd_addr_in,
    output reg  [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];

    always @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule

// *** dv/swf_frame_properties.sv ***
// concurrent checks on the write frame engine ports
`timescale 1ns/10ps
`include "swf_defs.vh"
module swf_frame_properties (
    input wire        clk_sys_in,
    input wire        nrst_in,
    input wire        ascii_mode_in,
    input wire [7:0]  station_addr_in,
    input wire        tx_ready_in,
    input wire        tx_valid_out,
    input wire [7:0]  tx_data_out,
    input wire        wr_valid_out,
    input wire [15:0] wr_addr_out,
    input wire        frame_ok_out,
    input wire        frame_err_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_take;
        tx_valid_out && tx_ready_in;
    endsequence
    sequence s_take_cr;
        s_take ##0 (ascii_mode_in && tx_data_out == `SWF_CH_CR);
    endsequence
    sequence s_take_lf;
        s_take ##0 (ascii_mode_in && tx_data_out == `SWF_CH_LF);
    endsequence

    a_ok_writes: assert property (frame_ok_out |-> ##2 wr_valid_out)
        else $error("no write after accepted frame");
    a_wr_ascend: assert property (wr_valid_out ##2 wr_valid_out
        |-> wr_addr_out == $past(wr_addr_out, 2) + 16'h0001)
        else $error("write addresses not ascending");
    a_wr_pulse: assert property (wr_valid_out |=> !wr_valid_out)
        else $error("write strobe longer than one cycle");
    a_err_quiet: assert property (frame_err_out |=> (!wr_valid_out && !tx_valid_out) [*4])
        else $error("activity after rejected frame");
    a_ok_excl: assert property (!(frame_ok_out && frame_err_out))
        else $error("accept and reject together");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
        else $error("response char changed while stalled");
    a_rtu_addr: assert property (!ascii_mode_in && $rose(tx_valid_out) |-> tx_data_out == station_addr_in)
        else $error("binary answer not led by station address");
    a_ascii_colon: assert property (ascii_mode_in && $rose(tx_valid_out) |-> tx_data_out == `SWF_CH_COLON)
        else $error("ascii answer not led by colon");
    a_cr_then_lf: assert property (s_take_cr |=> tx_valid_out && tx_data_out == `SWF_CH_LF)
        else $error("carriage return not followed by line feed");
    a_lf_last: assert property (s_take_lf |=> !tx_valid_out)
        else $error("characters after line feed");
    a_ascii_hex: assert property (ascii_mode_in && tx_valid_out && tx_data_out != `SWF_CH_COLON
        && tx_data_out != `SWF_CH_CR && tx_data_out != `SWF_CH_LF
        |-> (tx_data_out >= 8'h30 && tx_data_out <= 8'h39) || (tx_data_out >= 8'h41 && tx_data_out <= 8'h46))
        else $error("ascii char not uppercase hex");
    a_wr_no_tx: assert property (wr_valid_out |-> !tx_valid_out)
        else $error("answer started before writes ended");
endmodule

bind swf_frame swf_frame_properties u_swf_frame_properties (
    .clk_sys_in      (clk_sys_in),
    .nrst_in         (nrst_in),
    .ascii_mode_in   (ascii_mode_in),
    .station_addr_in (station_addr_in),
    .tx_ready_in     (tx_ready_in),
    .tx_valid_out    (tx_valid_out),
    .tx_data_out     (tx_data_out),
    .wr_valid_out    (wr_valid_out),
    .wr_addr_out     (wr_addr_out),
    .frame_ok_out    (frame_ok_out),
    .frame_err_out   (frame_err_out)
);

// *** dv/swf_host_sink.sv ***
// host side sink collecting answer characters with stalls
`timescale 1ns/10ps
module swf_host_sink (
    input  wire       clk_sys_in,
    input  wire       valid_in,
    input  wire [7:0] data_in,
    output wire       ready_out
);
    logic [7:0] got[$];
    logic [7:0] sr = 8'h5b;
    // ready follows the stall pattern, changes only after an edge
    assign ready_out = sr[0] | sr[2];
    always @(posedge clk_sys_in) begin
        if (valid_in && ready_out)
            got.push_back(data_in);
        sr <= {sr[6:0], sr[7] ^ sr[5] ^ sr[4] ^ sr[3]};
    end
endmodule

// *** dv/tb_swf_frame.sv ***
// self-checking bench for the write frame engine
`timescale 1ns/10ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %s", $time, m); end end
module tb_swf_frame;
    typedef logic [7:0] swf_bq_t[$];
    logic        clk_sys_in, nrst_in, ascii_mode_in, rx_valid_in, rx_frame_end_in;
    logic [7:0]  station_addr_in, rx_byte_in, tx_data_out;
    wire         tx_ready_in;
    logic        tx_valid_out, wr_valid_out, frame_ok_out, frame_err_out, busy_out;
    logic [15:0] wr_addr_out, wr_data_out;
    int          n_fail, compares, n_ok, n_err;
    logic [31:0] seed = 32'h03a6;
    logic [31:0] got_w[$];
    logic [31:0] exp_w[$];

    swf_frame u_swf_frame (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ascii_mode_in(ascii_mode_in),
        .station_addr_in(station_addr_in), .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
        .rx_frame_end_in(rx_frame_end_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out), .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out),
        .wr_data_out(wr_data_out), .frame_ok_out(frame_ok_out), .frame_err_out(frame_err_out),
        .busy_out(busy_out));
    swf_host_sink u_swf_host_sink (.clk_sys_in(clk_sys_in), .valid_in(tx_valid_out),
        .data_in(tx_data_out), .ready_out(tx_ready_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
    endfunction
    function automatic swf_bq_t enc(input logic m, input logic bad, input swf_bq_t b);
        swf_bq_t t, o;
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hffff;
        s = 8'h00;
        t = b;
        foreach (b[i]) begin
            s = s + b[i];
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        if (!m) begin
            t.push_back(c[7:0]);
            t.push_back(c[15:8] ^ {7'h00, bad});
            return t;
        end
        t.push_back(8'h00 - s + {7'h00, bad});
        o.push_back(8'h3a);
        foreach (t[i]) begin
            o.push_back(hx(t[i][7:4]));
            o.push_back(hx(t[i][3:0]));
        end
        o.push_back(8'h0d);
        o.push_back(8'h0a);
        return o;
    endfunction

    task automatic conclude();
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic run(input logic m, input logic [7:0] a, input logic [7:0] fn, input int n, input logic bad);
        swf_bq_t b, w, r;
        logic [15:0] st;
        logic ok;
        int cnt, ok0, er0;
        ok0 = n_ok;
        er0 = n_err;
        seed = lfsr(seed);
        st = {1'b0, seed[14:0]};
        b = '{a, fn, st[15:8], st[7:0]};
        got_w.delete();
        exp_w.delete();
        u_swf_host_sink.got.delete();
        if (fn != 8'h06) begin
            b.push_back(n[15:8]);
            b.push_back(n[7:0]);
            b.push_back(8'(2 * n));
        end
        for (int k = 0; k < ((fn == 8'h06) ? 1 : n); k++) begin
            seed = lfsr(seed);
            b.push_back(seed[15:8]);
            b.push_back(seed[7:0]);
            exp_w.push_back({st + 16'(k), seed[15:0]});
        end
        ok = a == 8'h01 && !bad && (fn == 8'h06 || (fn == 8'h10 && n > 0 && n <= 20));
        if (!ok)
            exp_w.delete();
        if (ok)
            r = enc(m, 1'b0, b[0:5]);
        w = enc(m, bad, b);
        // a cut fragment ahead of the frame, the second colon restarts it
        if (m && fn == 8'h06)
            w = {8'h3a, 8'h30, 8'h31, w};
        @(posedge clk_sys_in) ascii_mode_in <= m;
        foreach (w[i]) begin
            @(posedge clk_sys_in);
            rx_valid_in <= 1'b1;
            rx_byte_in <= w[i];
        end
        @(posedge clk_sys_in);
        rx_valid_in <= 1'b0;
        rx_frame_end_in <= !m;
        @(posedge clk_sys_in);
        rx_frame_end_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        cnt = 0;
        while (busy_out !== 1'b0 && cnt < 4000) begin
            @(posedge clk_sys_in);
            cnt++;
        end
        `CHK(cnt < 4000, 1'b1, "busy timeout")
        repeat (2) @(posedge clk_sys_in);
        `CHK(n_ok - ok0, ok ? 1 : 0, "accept count")
        `CHK(n_err - er0, (a == 8'h01 && !ok) ? 1 : 0, "reject count")
        `CHK(got_w.size(), exp_w.size(), "write count")
        foreach (exp_w[i])
            if (i < got_w.size()) `CHK(got_w[i], exp_w[i], "write value")
        `CHK(u_swf_host_sink.got.size(), r.size(), "answer length")
        foreach (r[i])
            if (i < u_swf_host_sink.got.size()) `CHK(u_swf_host_sink.got[i], r[i], "answer char")
    endtask

    always @(posedge clk_sys_in) begin
        if (frame_ok_out === 1'b1)
            n_ok++;
        if (frame_err_out === 1'b1)
            n_err++;
        if (wr_valid_out === 1'b1)
            got_w.push_back({wr_addr_out, wr_data_out});
        if (frame_ok_out === 1'b1 || frame_err_out === 1'b1 || wr_valid_out === 1'b1 || tx_valid_out === 1'b1)
            `CHK(busy_out, 1'b1, "busy low while working")
    end

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        #1000000;
        n_fail++;
        conclude();
    end

    initial begin
        nrst_in = 1'b0;
        ascii_mode_in = 1'b0;
        station_addr_in = 8'h01;
        rx_valid_in = 1'b0;
        rx_byte_in = 8'h00;
        rx_frame_end_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        for (int m = 0; m < 2; m++) begin
            run(m[0], 8'h01, 8'h06, 1, 1'b0);
            run(m[0], 8'h01, 8'h10, 20, 1'b0);
            run(m[0], 8'h01, 8'h10, 1, 1'b1);
            run(m[0], 8'h01, 8'h10, 21, 1'b0);
        end
        run(1'b0, 8'h01, 8'h10, 0, 1'b0);
        run(1'b0, 8'h02, 8'h10, 2, 1'b0);
        run(1'b0, 8'h01, 8'h03, 2, 1'b0);
        conclude();
    end
endmodule
